//--- verilog/arsc_pkg.sv
package arsc_pkg;
  localparam int NUM_CH = 3;
  localparam int DATA_W = 24;
  localparam int MOD_W = 4;
  // Register byte addresses on the bus
  localparam logic [3:0] OFS_CONFIG0 = 4'h0;
  localparam logic [3:0] OFS_SECOND_CONFIGURATION_REGISTER = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_MODOUT = 4'hc;
  // Field positions in CONFIG0 (soft reset bits)
  localparam int F_SRST_LSB = 0;
  // Field positions in SECOND_CONFIGURATION_REGISTER
  localparam int F_PDN_LSB = 0;
  localparam int F_EXTERNAL_REFERENCE_SELECT = 3;
  localparam int F_EXTERNAL_CLOCK_SELECT = 4;
  // Reset values
  localparam logic [2:0] RST_SRST = 3'h0;
  localparam logic [2:0] RST_PDN = 3'h0;
  localparam logic RST_EXTSEL = 1'b0;
  localparam logic [MOD_W-1:0] MOD_DEFAULT = 4'h3;
  localparam logic [2:0] ALL_CH = 3'h7;
  // Filter settling in sample periods and sample period in sys_clk cycles
  localparam int SETTLE_SAMPLES = 3;
  localparam int SAMPLE_CYCLES = 16;
  localparam int SAMP_CNT_W = 8;

  typedef struct packed {
    logic [2:0] soft_reset;
    logic [2:0] power_down;
    logic external_reference_select;
    logic external_clock_select;
  } arsc_cfg_t;

  typedef struct packed {
    logic core_clk_en;
    logic input_clk_en;
    logic full_shutdown;
    logic supply_mon_en;
    logic vref_int_en;
    logic spi_in_reset;
  } arsc_pwr_t;
endpackage : arsc_pkg

//--- verilog/arsc_ctrl.sv
// Summary of operation
// - Soft reset bit forces channel output zero
// - Soft reset sets quantizer code to 0011
// - Valid codes right after filter settling
// - Per-channel soft reset, registers untouched
// - No data ready during soft reset
// - Keep phase, realign to running channel
// - Clock keeps running for other channels
// - All soft reset stops core clock
// - All soft reset keeps input clocked
// - Hard reset restores register defaults
// - Hard reset clears data, resets filters, codes to 0011
// - Serial interface held in hard reset
// - Power-up enables channel, ready after settling
// - Power-down only via config bits, independent
// - Powered-down channel zero data, no ready
// - Power-down exit keeps phase, resynchronises
// - All powered down stops all clocks
// - Full shutdown disables analog, monitors, clocks
// - Full shutdown keeps register contents
// - Serial interface alive in full shutdown
// - Any bit cleared leaves full shutdown
`timescale 1ns/1ns
module arsc_ctrl #(
  parameter int NCH = arsc_pkg::NUM_CH,
  parameter int DW = arsc_pkg::DATA_W,
  parameter int SETTLE = arsc_pkg::SETTLE_SAMPLES,
  parameter int PERIOD = arsc_pkg::SAMPLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic reset_pin_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NCH*DW-1:0] conv_data,
  input wire logic [NCH*arsc_pkg::MOD_W-1:0] conv_mod,
  output logic [NCH*DW-1:0] out_data,
  output logic [NCH*arsc_pkg::MOD_W-1:0] modulator_output_register,
  output logic [NCH-1:0] data_ready,
  output logic [NCH-1:0] filter_reset,
  output arsc_pkg::arsc_pwr_t pwr
);
  import arsc_pkg::*;

  logic rst_s1;
  logic rst_s2;
  logic hard_rst;
  arsc_cfg_t cfg;
  logic [NCH-1:0] pdn_eff;
  logic [NCH-1:0] srst_eff;
  logic [NCH-1:0] active;
  logic [NCH-1:0] active_q;
  logic [SAMP_CNT_W-1:0] samp_cnt;
  logic samp_tick;
  logic [SAMP_CNT_W-1:0] settle_cnt [NCH];
  logic acc_pending;
  logic acc_done;
  logic [31:0] wr_merged;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  assign wr_merged = lane_merge(32'h0, avs_writedata, avs_byteenable);

  // Pin synchroniser; reset pin acts as hard reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else if (clk_en) begin
      rst_s1 <= reset_pin_n;
      rst_s2 <= rst_s1;
    end
  end
  assign hard_rst = !rst_s2;

  // Power-down dominates soft reset on the same channel
  assign pdn_eff = cfg.power_down;
  assign srst_eff = cfg.soft_reset & ~cfg.power_down;
  assign active = ~(pdn_eff | srst_eff);

  // Config registers: only bus writes change them, hard reset restores defaults
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg.soft_reset <= RST_SRST;
      cfg.power_down <= RST_PDN;
      cfg.external_reference_select <= RST_EXTSEL;
      cfg.external_clock_select <= RST_EXTSEL;
    end else if (clk_en) begin
      if (hard_rst) begin
        cfg.soft_reset <= RST_SRST;
        cfg.power_down <= RST_PDN;
        cfg.external_reference_select <= RST_EXTSEL;
        cfg.external_clock_select <= RST_EXTSEL;
      end else if (acc_done && avs_write) begin
        // Mode bits enter only by writes; modes never write back
        case (avs_address)
          OFS_CONFIG0: begin
            cfg.soft_reset <= wr_merged[F_SRST_LSB +: 3];
          end
          OFS_SECOND_CONFIGURATION_REGISTER: begin
            cfg.power_down <= avs_writedata[F_PDN_LSB +: 3];
            cfg.external_reference_select <= avs_writedata[F_EXTERNAL_REFERENCE_SELECT];
            cfg.external_clock_select <= avs_writedata[F_EXTERNAL_CLOCK_SELECT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Bus slave: one wait cycle, then answer; refused entirely in hard reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      acc_pending <= 1'b0;
    end else if (clk_en) begin
      if (hard_rst) begin
        acc_pending <= 1'b0;
      end else if (acc_done) begin
        acc_pending <= 1'b0;
      end else if (avs_read || avs_write) begin
        acc_pending <= 1'b1;
      end
    end
  end
  assign acc_done = acc_pending && (avs_read || avs_write) && !hard_rst && clk_en;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= !((avs_read || avs_write) && !acc_pending && !hard_rst);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0;
    end else if (clk_en) begin
      if (avs_read && !acc_pending) begin
        case (avs_address)
          OFS_CONFIG0: avs_readdata <= {29'h0, cfg.soft_reset};
          OFS_SECOND_CONFIGURATION_REGISTER: avs_readdata <= {27'h0, cfg.external_clock_select,
                                        cfg.external_reference_select, cfg.power_down};
          OFS_STATUS: avs_readdata <= {26'h0, pwr};
          OFS_MODOUT: avs_readdata <= {20'h0, modulator_output_register};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // Free-running sample timebase; never stops for a single channel
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      samp_cnt <= '0;
    end else if (clk_en) begin
      if (hard_rst || samp_tick) begin
        samp_cnt <= '0;
      end else if (pwr.core_clk_en) begin
        samp_cnt <= samp_cnt + 1'b1;
      end
    end
  end
  assign samp_tick = pwr.core_clk_en && (samp_cnt == SAMP_CNT_W'(PERIOD - 1));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      active_q <= '0;
    end else if (clk_en) begin
      active_q <= hard_rst ? '0 : active;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // Settling count restarts on exit; ready aligned to the shared sample tick
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        settle_cnt[c] <= '0;
      end else if (clk_en) begin
        if (hard_rst || !active[c]) begin
          settle_cnt[c] <= SAMP_CNT_W'(SETTLE);
        end else if (samp_tick && settle_cnt[c] != '0) begin
          settle_cnt[c] <= settle_cnt[c] - 1'b1;
        end
      end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        data_ready[c] <= 1'b0;
      end else if (clk_en) begin
        // Phase kept: shared tick is the realignment reference
        data_ready[c] <= !hard_rst && active[c] && samp_tick
                         && settle_cnt[c] == '0;
      end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        out_data[c*DW +: DW] <= '0;
      end else if (clk_en) begin
        if (hard_rst || !active[c]) begin
          out_data[c*DW +: DW] <= '0;
        end else if (samp_tick && settle_cnt[c] == '0) begin
          out_data[c*DW +: DW] <= conv_data[c*DW +: DW];
        end
      end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        modulator_output_register[c*MOD_W +: MOD_W] <= MOD_DEFAULT;
      end else if (clk_en) begin
        if (hard_rst || srst_eff[c]) begin
          modulator_output_register[c*MOD_W +: MOD_W] <= MOD_DEFAULT;
        end else if (!pdn_eff[c]) begin
          modulator_output_register[c*MOD_W +: MOD_W] <= conv_mod[c*MOD_W +: MOD_W];
        end
      end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        filter_reset[c] <= 1'b1;
      end else if (clk_en) begin
        filter_reset[c] <= hard_rst || !active[c];
      end
    end
  end

  // Clock gating and power control, registered
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwr <= '0;
    end else if (clk_en) begin
      pwr.core_clk_en <= !hard_rst && (active != '0);
      pwr.input_clk_en <= hard_rst || (pdn_eff != ALL_CH);
      pwr.full_shutdown <= !hard_rst && cfg.power_down == ALL_CH
                           && cfg.external_reference_select
                           && cfg.external_clock_select;
      pwr.supply_mon_en <= hard_rst || !(cfg.power_down == ALL_CH
                           && cfg.external_reference_select
                           && cfg.external_clock_select);
      pwr.vref_int_en <= !hard_rst && !cfg.external_reference_select;
      pwr.spi_in_reset <= hard_rst;
    end
  end

  AST_NO_READY_INACTIVE: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !active[0] |=> !data_ready[0])
    else $error("data ready while channel inactive");
  AST_ZERO_PDN: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && pdn_eff[1] |=> out_data[DW +: DW] == '0)
    else $error("powered-down output not zero");
  AST_MOD_DEFAULT: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && srst_eff[0] |=> modulator_output_register[0 +: MOD_W] == MOD_DEFAULT)
    else $error("soft reset code wrong");
  AST_CORE_CLK_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && active == '0 |=> !pwr.core_clk_en)
    else $error("core clock runs with all channels idle");
  AST_INPUT_CLK_SRST: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && srst_eff == ALL_CH |=> pwr.input_clk_en)
    else $error("input clock stopped in soft reset");
  AST_FULL_SD: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !hard_rst && cfg.power_down == ALL_CH && cfg.external_reference_select
    && cfg.external_clock_select |=> pwr.full_shutdown && !pwr.supply_mon_en)
    else $error("full shutdown not entered");
  AST_SPI_HELD: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && hard_rst |=> avs_waitrequest && pwr.spi_in_reset)
    else $error("bus answered in hard reset");
  AST_CFG_DEFAULT: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && hard_rst |=> cfg.soft_reset == RST_SRST && cfg.power_down == RST_PDN)
    else $error("config not defaulted by hard reset");
  AST_SETTLE: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && $rose(active[2]) |-> settle_cnt[2] == SAMP_CNT_W'(SETTLE))
    else $error("settling not restarted");

  // Per-channel quieting and zeroing
  AST_NO_READY_CH1: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !active[1] |=> !data_ready[1])
    else $error("data ready on idle channel one");
  AST_NO_READY_CH2: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !active[2] |=> !data_ready[2])
    else $error("data ready on idle channel two");
  AST_ZERO_PDN0: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && pdn_eff[0] |=> out_data[0 +: DW] == '0)
    else $error("powered-down output zero not zero");
  AST_ZERO_PDN2: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && pdn_eff[2] |=> out_data[2*DW +: DW] == '0)
    else $error("powered-down output two not zero");
  AST_ZERO_SRST0: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && srst_eff[0] |=> out_data[0 +: DW] == '0)
    else $error("soft reset output zero not zero");
  AST_ZERO_SRST1: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && srst_eff[1] |=> out_data[DW +: DW] == '0)
    else $error("soft reset output one not zero");
  AST_MOD_DEFAULT1: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && srst_eff[1] |=> modulator_output_register[MOD_W +: MOD_W] == MOD_DEFAULT)
    else $error("soft reset code wrong on channel one");
  AST_MOD_DEFAULT2: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && srst_eff[2] |=> modulator_output_register[2*MOD_W +: MOD_W] == MOD_DEFAULT)
    else $error("soft reset code wrong on channel two");
  AST_PDN_WINS: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && cfg.power_down[0] && cfg.soft_reset[0] |=> !data_ready[0]
    && out_data[0 +: DW] == '0)
    else $error("soft reset overrode power-down");

  // Clock distribution and shutdown
  AST_CORE_CLK_ON: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !hard_rst && active != '0 |=> pwr.core_clk_en)
    else $error("core clock not restored");
  AST_INPUT_CLK_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !hard_rst && pdn_eff == ALL_CH |=> !pwr.input_clk_en)
    else $error("input clock runs with all powered down");
  AST_INPUT_CLK_ON: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && pdn_eff != ALL_CH |=> pwr.input_clk_en)
    else $error("input clock not restored");
  AST_SD_EXIT: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !hard_rst && (cfg.power_down != ALL_CH || !cfg.external_reference_select
    || !cfg.external_clock_select) |=> !pwr.full_shutdown && pwr.supply_mon_en)
    else $error("full shutdown not left");
  AST_VREF_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && cfg.external_reference_select |=> !pwr.vref_int_en)
    else $error("internal reference left on");
  AST_SD_CLOCKS: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && pwr.full_shutdown |-> !pwr.core_clk_en && !pwr.input_clk_en)
    else $error("clock runs in full shutdown");

  // Hard reset effects
  AST_FILTER_RST: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && hard_rst |=> filter_reset == '1)
    else $error("filters not reset");
  AST_DATA_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && hard_rst |=> out_data == '0 && data_ready == '0)
    else $error("data not cleared in hard reset");
  AST_MOD_HARD: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && hard_rst |=> modulator_output_register == {NCH{MOD_DEFAULT}})
    else $error("codes not defaulted in hard reset");
  AST_CFG_EXT_DEFAULT: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && hard_rst |=> !cfg.external_reference_select && !cfg.external_clock_select)
    else $error("select bits not defaulted");

  // Bus and register retention
  AST_BUS_ANSWER: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !hard_rst && avs_read && !acc_pending |=> !avs_waitrequest)
    else $error("bus not answered");
  AST_WAIT_ONE: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  AST_SPI_FREE: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !hard_rst |=> !pwr.spi_in_reset)
    else $error("serial interface held without hard reset");
  AST_CFG_KEEP: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !hard_rst && !(acc_done && avs_write) |=> $stable(cfg))
    else $error("config changed without a write");

  // Settling and alignment
  AST_SETTLE0: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && $rose(active[0]) |-> settle_cnt[0] == SAMP_CNT_W'(SETTLE))
    else $error("settling not restarted on channel zero");
  AST_READY_SETTLED: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && settle_cnt[1] != '0 |=> !data_ready[1])
    else $error("data ready before settling");
  AST_READY_TICK: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !samp_tick |=> data_ready == '0)
    else $error("data ready off the shared tick");
  AST_PHASE_KEEP: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !hard_rst && samp_tick && active[1:0] == 2'b11 && settle_cnt[0] == '0
    && settle_cnt[1] == '0 |=> data_ready[0] && data_ready[1])
    else $error("settled channels not aligned");
  AST_MOD_PASS: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !hard_rst && active[0] |=>
    modulator_output_register[0 +: MOD_W] == $past(conv_mod[0 +: MOD_W]))
    else $error("quantizer code not passed through");
endmodule : arsc_ctrl

//--- testbench/arsc_host.sv
`timescale 1ns/1ns
module arsc_host (
  input wire logic sys_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  output logic reset_pin_n
);
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    reset_pin_n = 1'b1;
  end

  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (!avs_waitrequest) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Stale values would hide a decoder that ignores the strobes
    avs_address <= ~a;
    avs_writedata <= ~d;
    if (i == 50) begin
      test_adc_reset_shutdown_control.errors++;
      test_adc_reset_shutdown_control.tally_and_finish();
    end
  endtask : xfer

  // Caller keeps off the bus while the pin is low
  task automatic pin(input logic v);
    @(posedge sys_clk);
    reset_pin_n <= v;
  endtask : pin
endmodule : arsc_host

//--- testbench/test_adc_reset_shutdown_control.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_adc_reset_shutdown_control;
  import arsc_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic reset_pin_n;
  logic [3:0] avs_address, avs_byteenable;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [71:0] conv_data = '0;
  logic [71:0] out_data;
  logic [71:0] conv_q;
  logic [23:0] held;
  logic [11:0] conv_mod = '0;
  logic [11:0] mod_out;
  logic [2:0] data_ready, filter_reset, m;
  arsc_pwr_t pwr;
  logic [31:0] cs = 32'he761;
  logic [31:0] rs = 32'he761;
  int errors = 0;
  int n_tests = 0;
  int n;
  localparam int LO = (SETTLE_SAMPLES - 1) * SAMPLE_CYCLES;
  localparam int HI = (SETTLE_SAMPLES + 2) * SAMPLE_CYCLES;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cs <= xs(cs);
    conv_data <= {3{cs[23:0]}};
    conv_mod <= cs[11:0];
    conv_q <= conv_data;
  end

  arsc_ctrl i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .reset_pin_n(reset_pin_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_data(conv_data), .conv_mod(conv_mod), .out_data(out_data),
    .modulator_output_register(mod_out), .data_ready(data_ready),
    .filter_reset(filter_reset), .pwr(pwr)
  );

  arsc_host i_host (
    .sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .reset_pin_n(reset_pin_n)
  );

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
    repeat (4) @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    i_host.xfer(1'b0, a, 32'h0, q);
  endtask : rd

  // Waits for the ready pulse after power-up; callers judge its timing and first value
  task automatic wait_dr(input int ch);
    for (n = 0; n < 200 && data_ready[ch] !== 1'b1; n++) @(posedge sys_clk);
    if (n == 200) begin
      errors++;
      tally_and_finish();
    end
  endtask : wait_dr

  task automatic quiet(input logic [2:0] msk);
    logic bad;
    bad = 1'b0;
    repeat (40) begin
      @(posedge sys_clk);
      bad |= |(data_ready & msk);
    end
    `CHK(bad, 1'b0)
  endtask : quiet

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (12) @(posedge sys_clk);
    `CHK(mod_out, 12'h333)
    `CHK(filter_reset, 3'h7)
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wr(4'h2, 32'hffffffff);
    rd(4'h2);
    `CHK(q, 32'h0)
    rd(OFS_SECOND_CONFIGURATION_REGISTER);
    `CHK(q[4:0], 5'h0)
    $display("test defaults done");
    for (int t = 0; t < 5; t++) begin
      rs = xs(rs);
      m = (t == 0) ? ALL_CH : (t == 1) ? 3'h5 : rs[2:0];
      wr(OFS_CONFIG0, {29'h0, m});
      rd(OFS_CONFIG0);
      `CHK(q[2:0], m)
      rd(OFS_SECOND_CONFIGURATION_REGISTER);
      `CHK(q[4:0], 5'h0)
      for (int c = 0; c < 3; c++) if (m[c]) begin
        `CHK(mod_out[c*4+:4], MOD_DEFAULT)
        `CHK(out_data[c*24+:24], 24'h0)
      end
      `CHK(pwr.core_clk_en, m != ALL_CH)
      `CHK(pwr.input_clk_en, 1'b1)
      quiet(m);
    end
    $display("test soft reset done");
    wr(OFS_CONFIG0, 32'h1);
    wait_dr(1);
    wr(OFS_CONFIG0, 32'h0);
    wait_dr(0);
    `CHK(data_ready[1], 1'b1)
    `CHK(n inside {[LO:HI]}, 1'b1)
    `CHK(out_data[23:0], conv_q[23:0])
    wr(OFS_CONFIG0, 32'h1);
    wr(OFS_SECOND_CONFIGURATION_REGISTER, 32'h1);
    `CHK(out_data[23:0], 24'h0)
    quiet(3'h1);
    wr(OFS_CONFIG0, 32'h0);
    quiet(3'h1);
    `CHK(out_data[23:0], 24'h0)
    wr(OFS_SECOND_CONFIGURATION_REGISTER, 32'h0);
    wait_dr(0);
    `CHK(data_ready[1], 1'b1)
    `CHK(n inside {[LO:HI]}, 1'b1)
    $display("test channel power-down done");
    held = out_data[23:0];
    clk_en <= 1'b0;
    quiet(3'h7);
    `CHK(out_data[23:0], held)
    clk_en <= 1'b1;
    $display("test clock enable done");
    wr(OFS_SECOND_CONFIGURATION_REGISTER, 32'h7);
    `CHK({pwr.core_clk_en, pwr.input_clk_en}, 2'b00)
    `CHK(pwr.full_shutdown, 1'b0)
    wr(OFS_CONFIG0, 32'h2);
    for (int b = 0; b < 5; b++) begin
      wr(OFS_SECOND_CONFIGURATION_REGISTER, 32'h1f);
      rd(OFS_SECOND_CONFIGURATION_REGISTER);
      `CHK(q[4:0], 5'h1f)
      `CHK(pwr.full_shutdown, 1'b1)
      `CHK({pwr.supply_mon_en, pwr.vref_int_en}, 2'b00)
      `CHK({pwr.core_clk_en, pwr.input_clk_en}, 2'b00)
      wr(OFS_SECOND_CONFIGURATION_REGISTER, 32'h1f ^ (32'h1 << b));
      `CHK(pwr.full_shutdown, 1'b0)
      `CHK(pwr.supply_mon_en, 1'b1)
    end
    rd(OFS_CONFIG0);
    `CHK(q[2:0], 3'h2)
    $display("test full shutdown done");
    wr(OFS_SECOND_CONFIGURATION_REGISTER, 32'h0);
    repeat (80) @(posedge sys_clk);
    i_host.pin(1'b0);
    repeat (6) @(posedge sys_clk);
    `CHK(pwr.spi_in_reset, 1'b1)
    `CHK(avs_waitrequest, 1'b1)
    `CHK(mod_out, 12'h333)
    `CHK(out_data, 72'h0)
    `CHK(filter_reset, 3'h7)
    i_host.pin(1'b1);
    repeat (4) @(posedge sys_clk);
    rd(OFS_CONFIG0);
    `CHK(q[2:0], RST_SRST)
    $display("test hard reset done");
    tally_and_finish();
  end
endmodule : test_adc_reset_shutdown_control
